// >>> hdl/pcd_pkg.sv
// Purpose: shared constants for the pulse-count LED dimmer link
// Assumes: 125 MHz reference clock on both ends
// Notes:   times are kept in their printed units, counts derived from them
package pcd_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ          = 125;
    localparam int SHDN_LOW_US      = 1500;   // 1.5 ms
    localparam int PUMP_DELAY_US    = 400;
    localparam int SETUP_HIGH_US    = 10;
    localparam int PULSE_MIN_NS     = 300;
    localparam int PULSE_MAX_US     = 200;
    localparam int SHDN_LOW_CYC     = SHDN_LOW_US * CLK_MHZ;
    localparam int PUMP_DELAY_CYC   = PUMP_DELAY_US * CLK_MHZ;
    localparam int SETUP_HIGH_CYC   = SETUP_HIGH_US * CLK_MHZ;
    localparam int PULSE_MIN_CYC    = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_MAX_CYC    = PULSE_MAX_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Current levels
    // ----------------------------------------------------------------
    localparam int STEP_W           = 5;
    localparam int LEVEL_W          = 8;
    localparam logic [STEP_W-1:0] STEP_FULL = 5'h00;
    localparam logic [STEP_W-1:0] STEP_ZERO = 5'h1f;
    localparam logic [LEVEL_W-1:0] LEVEL_FULL = 8'h96; // 150 mA

    typedef enum logic [1:0] {
        PCD_SHUTDOWN,
        PCD_ARMED,
        PCD_ACTIVE
    } pcd_state_e;

    typedef enum logic {
        PCD_GAIN_1X,
        PCD_GAIN_1P5X
    } pcd_gain_e;

endpackage : pcd_pkg

// >>> hdl/pcd_link_if.sv
// Purpose: single-wire enable/dim line between host and dimmer
// Assumes: host is the only driver of the line
// Notes:   level is a plain wire, no tristate needed
`timescale 1ns/1ps
interface pcd_link_if;
    logic enable_dim_input;
    modport host   (output enable_dim_input);
    modport device (input  enable_dim_input);
endinterface : pcd_link_if

// >>> hdl/pcd_level_lut.sv
// Purpose: maps a 5-bit step index to a per-channel current in 0.5 mA units
// Assumes: index 0 is full scale, index 31 is zero
// Notes:   registered output so the top drives sinks from a flip-flop
`timescale 1ns/1ps
module pcd_level_lut
    import pcd_pkg::*;
(
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    input  wire logic [STEP_W-1:0]  step_i,
    output logic      [LEVEL_W:0]   half_ma_o
);

    // ----------------------------------------------------------------
    // Table
    // ----------------------------------------------------------------
    // Values in half-milliamps, following the pulse-count table
    function automatic logic [LEVEL_W:0] lut(input logic [STEP_W-1:0] s);
        logic [LEVEL_W:0] v;
        case (s)
            5'h00: v = 9'h12c; 5'h01: v = 9'h122; 5'h02: v = 9'h118; 5'h03: v = 9'h10f;
            5'h04: v = 9'h106; 5'h05: v = 9'h0fc; 5'h06: v = 9'h0f2; 5'h07: v = 9'h0e8;
            5'h08: v = 9'h0de; 5'h09: v = 9'h0d5; 5'h0a: v = 9'h0cb; 5'h0b: v = 9'h0c2;
            5'h0c: v = 9'h0b8; 5'h0d: v = 9'h0ae; 5'h0e: v = 9'h0a4; 5'h0f: v = 9'h09b;
            5'h10: v = 9'h091; 5'h11: v = 9'h088; 5'h12: v = 9'h07e; 5'h13: v = 9'h074;
            5'h14: v = 9'h06a; 5'h15: v = 9'h061; 5'h16: v = 9'h057; 5'h17: v = 9'h04e;
            5'h18: v = 9'h044; 5'h19: v = 9'h03a; 5'h1a: v = 9'h030; 5'h1b: v = 9'h026;
            5'h1c: v = 9'h01d; 5'h1d: v = 9'h014; 5'h1e: v = 9'h00a;
            default: v = 9'h000;
        endcase
        return v;
    endfunction : lut

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            half_ma_o <= '0;
        end else begin
            half_ma_o <= lut(step_i);
        end
    end

endmodule : pcd_level_lut

// >>> hdl/pcd_dimmer.sv
// What this block does
// - first rise enables, currents stay zero
// - first falling edge loads full scale
// - each further fall steps down one
// - thirty-second pulse gives zero, stays enabled
// - pulse after zero wraps to full
// - low for 1.5 ms means shutdown
// - shutdown puts sinks in high impedance
// - one input, one count, both channels
// - undervoltage disables all channels
// - pump starts in unity gain
// - regulation loss switches to 1.5x after 400 us
// - pump sequence restarts on wake
// - host pulses 300 ns to 200 us
// - host spaces pulses 300 ns apart
// - pulse rate 5 kHz to 1 MHz
// - current follows pulse-count table
//
// Purpose: device end, decodes the enable/dim line into channel currents
// Assumes: undervoltage and regulation-fail come from analog comparators
// Notes:   current is reported in 0.5 mA units per channel
`timescale 1ns/1ps
module pcd_dimmer
    import pcd_pkg::*;
#(
    parameter int SHDN_CYC  = SHDN_LOW_CYC,
    parameter int PUMP_CYC  = PUMP_DELAY_CYC
) (
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    pcd_link_if.device             link,
    input  wire logic              undervolt_i,
    input  wire logic              reg_fail_i,
    output logic                   enabled_o,
    output logic       [LEVEL_W:0] channel_one_sink_o,
    output logic       [LEVEL_W:0] channel_two_sink_o,
    output logic                   sink_oe_o,
    output logic                   pump_gain_1p5x_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Gating is shared by both channels so they can never disagree
    function automatic logic [LEVEL_W:0] gated_level(
        input logic             on,
        input logic [LEVEL_W:0] lvl
    );
        return on ? lvl : '0;
    endfunction : gated_level

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic line_meta, line_sync, line_prev;
    logic uv_meta, uv_sync, rf_meta, rf_sync;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_meta <= 1'b0;
            line_sync <= 1'b0;
            line_prev <= 1'b0;
        end else begin
            line_meta <= link.enable_dim_input;
            line_sync <= line_meta;
            line_prev <= line_sync;
        end
    end

    // Supply starts suspect until the comparator says otherwise
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            uv_meta <= 1'b1;
            uv_sync <= 1'b1;
            rf_meta <= 1'b0;
            rf_sync <= 1'b0;
        end else begin
            uv_meta <= undervolt_i;
            uv_sync <= uv_meta;
            rf_meta <= reg_fail_i;
            rf_sync <= rf_meta;
        end
    end

    // Prev resets low like the line, so the first high reads as a wake
    // Any low or high of one sample or more is seen as an edge
    wire rise = line_sync & ~line_prev;
    wire fall = ~line_sync & line_prev;

    // ----------------------------------------------------------------
    // Low-time counter
    // ----------------------------------------------------------------
    logic [31:0] low_cnt;
    logic        low_expired;

    // Only length matters; any low shorter than shutdown is one step
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt     <= '0;
            low_expired <= 1'b0;
        end else if (line_sync) begin
            low_cnt     <= '0;
            low_expired <= 1'b0;
        end else if (!low_expired) begin
            low_cnt     <= low_cnt + 32'h1;
            // Set on the SHDN_CYC-th low sample; one fewer is still a step
            low_expired <= (low_cnt >= 32'(SHDN_CYC - 1));
        end
    end

    // ----------------------------------------------------------------
    // Enable state and step index
    // ----------------------------------------------------------------
    pcd_state_e        state;
    logic [STEP_W-1:0] step;
    logic              wake;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= PCD_SHUTDOWN;
            step  <= STEP_FULL;
            wake  <= 1'b0;
        end else begin
            wake <= 1'b0;
            case (state)
                PCD_SHUTDOWN: begin
                    // Full scale waits in the index so the first fall after
                    // a wake never shows a stale level for a cycle
                    step <= STEP_FULL;
                    if (rise) begin
                        state <= PCD_ARMED;
                        wake  <= 1'b1;
                    end
                end
                PCD_ARMED: if (low_expired) begin
                    state <= PCD_SHUTDOWN;
                end else if (fall) begin
                    state <= PCD_ACTIVE;
                    step  <= STEP_FULL;
                end
                PCD_ACTIVE: if (low_expired) begin
                    state <= PCD_SHUTDOWN;
                end else if (fall) begin
                    // 5-bit wrap: zero level rolls back to full
                    step <= step + 5'h01;
                end
                default: state <= PCD_SHUTDOWN;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Channel drive
    // ----------------------------------------------------------------
    logic [LEVEL_W:0] level;

    pcd_level_lut u_lut (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .step_i    (step),
        .half_ma_o (level)
    );

    // Count is kept through undervoltage; only the drive is gated
    wire drive = (state == PCD_ACTIVE) && !uv_sync;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enabled_o          <= 1'b0;
            sink_oe_o          <= 1'b0;
            channel_one_sink_o <= '0;
            channel_two_sink_o <= '0;
        end else begin
            enabled_o          <= (state != PCD_SHUTDOWN);
            sink_oe_o          <= (state != PCD_SHUTDOWN);
            channel_one_sink_o <= gated_level(drive, level);
            channel_two_sink_o <= gated_level(drive, level);
        end
    end

    // ----------------------------------------------------------------
    // Charge pump gain sequencer
    // ----------------------------------------------------------------
    logic [31:0] pump_cnt;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pump_cnt         <= '0;
            pump_gain_1p5x_o <= 1'b0;
        end else if (wake || state == PCD_SHUTDOWN) begin
            pump_cnt         <= '0;
            pump_gain_1p5x_o <= 1'b0;
        end else if (!pump_gain_1p5x_o) begin
            // A short recovery restarts the delay; the loss must persist
            if (!rf_sync) begin
                pump_cnt <= '0;
            end else if (pump_cnt >= 32'(PUMP_CYC - 1)) begin
                pump_gain_1p5x_o <= 1'b1;
            end else begin
                pump_cnt <= pump_cnt + 32'h1;
            end
        end
    end

endmodule : pcd_dimmer

// >>> hdl/pcd_host.sv
// Purpose: host end, turns level requests into pulse trains on the line
// Assumes: one request at a time, taken while ready_o is high
// Notes:   pulse low and high times are parameters within the legal window
`timescale 1ns/1ps
module pcd_host
    import pcd_pkg::*;
#(
    parameter int SETUP_CYC = SETUP_HIGH_CYC,
    parameter int SHDN_CYC  = SHDN_LOW_CYC,
    parameter int LOW_CYC   = 125,   // 1 us low, inside 300 ns..200 us
    parameter int HIGH_CYC  = 125
) (
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    pcd_link_if.host               link,
    input  wire logic              pulse_req_i,
    input  wire logic [STEP_W:0]   pulse_count_i,
    input  wire logic              shutdown_req_i,
    output logic                   ready_o
);

    typedef enum logic [2:0] {
        H_OFF, H_SETUP, H_IDLE, H_LOW, H_HIGH, H_SHDN
    } pcd_host_state_e;

    pcd_host_state_e  st;
    logic [31:0]      cnt;
    logic [STEP_W:0]  left;
    logic             line;

    assign link.enable_dim_input = line;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st      <= H_OFF;
            cnt     <= '0;
            left    <= '0;
            line    <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            case (st)
                H_OFF: begin
                    line <= 1'b1;
                    cnt  <= '0;
                    st   <= H_SETUP;
                end
                H_SETUP: if (cnt >= 32'(SETUP_CYC + 1)) begin
                    st      <= H_IDLE;
                    ready_o <= 1'b1;
                end else begin
                    cnt <= cnt + 32'h1;
                end
                H_IDLE: if (shutdown_req_i) begin
                    ready_o <= 1'b0;
                    line    <= 1'b0;
                    cnt     <= '0;
                    st      <= H_SHDN;
                end else if (pulse_req_i && pulse_count_i != '0) begin
                    ready_o <= 1'b0;
                    left    <= pulse_count_i;
                    line    <= 1'b0;
                    cnt     <= '0;
                    st      <= H_LOW;
                end
                H_LOW: if (cnt >= 32'(LOW_CYC - 1)) begin
                    line <= 1'b1;
                    cnt  <= '0;
                    left <= left - 6'h01;
                    st   <= H_HIGH;
                end else begin
                    cnt <= cnt + 32'h1;
                end
                H_HIGH: if (cnt >= 32'(HIGH_CYC - 1)) begin
                    cnt <= '0;
                    if (left == '0) begin
                        st      <= H_IDLE;
                        ready_o <= 1'b1;
                    end else begin
                        line <= 1'b0;
                        st   <= H_LOW;
                    end
                end else begin
                    cnt <= cnt + 32'h1;
                end
                H_SHDN: if (cnt >= 32'(SHDN_CYC + 7)) begin
                    st <= H_OFF;
                end else begin
                    cnt <= cnt + 32'h1;
                end
                default: st <= H_OFF;
            endcase
        end
    end

endmodule : pcd_host

// >>> dv/pcd_link_assertions.sv
// Purpose: checks dimmer outputs against the enable/dim line
// Assumes: one clock, line seen through a two-flop synchroniser
// Notes:   latency windows allow for sync, step, table and output flops
`timescale 1ns/1ps
module pcd_link_assertions
    import pcd_pkg::*;
#(
    parameter int SHDN_CYC = 200,
    parameter int PUMP_CYC = 100
) (
    input wire logic             ref_clk_i,
    input wire logic             resetn_i,
    input wire logic             enable_dim_input,
    input wire logic             undervolt_i,
    input wire logic             reg_fail_i,
    input wire logic             enabled_o,
    input wire logic [LEVEL_W:0] channel_one_sink_o,
    input wire logic [LEVEL_W:0] channel_two_sink_o,
    input wire logic             sink_oe_o,
    input wire logic             pump_gain_1p5x_o
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    int low_cnt;
    int fail_cnt;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) low_cnt <= 0;
        else if (enable_dim_input) low_cnt <= 0;
        else if (low_cnt < SHDN_CYC + 50) low_cnt <= low_cnt + 1;
    end
    // Saturate so long runs never wrap
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) fail_cnt <= 0;
        else if (!reg_fail_i || !enabled_o) fail_cnt <= 0;
        else if (fail_cnt < PUMP_CYC + 50) fail_cnt <= fail_cnt + 1;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence zero_fall_s;
        enabled_o && channel_one_sink_o == '0 && $fell(enable_dim_input);
    endsequence
    sequence step_fall_s;
        enabled_o && channel_one_sink_o != '0 && $fell(enable_dim_input);
    endsequence
    full_load_a: assert property (zero_fall_s |-> ##[3:7] channel_one_sink_o == 9'h12c)
        else $error("full scale not loaded after fall");
    step_down_a: assert property (step_fall_s |-> ##[3:7] (channel_one_sink_o <
        $past(channel_one_sink_o) && channel_one_sink_o + 9'd10 >= $past(channel_one_sink_o)))
        else $error("level did not step down by one");
    shut_long_a: assert property ($fell(enabled_o) |-> low_cnt >= SHDN_CYC + 4)
        else $error("shutdown after a short low");
    shut_due_a: assert property (low_cnt == SHDN_CYC + 6 |-> !enabled_o)
        else $error("no shutdown after long low");
    hiz_shut_a: assert property (!enabled_o |-> !sink_oe_o && channel_one_sink_o == '0)
        else $error("sinks driven in shutdown");
    chan_same_a: assert property (channel_one_sink_o == channel_two_sink_o)
        else $error("channels differ");
    uv_off_a: assert property (undervolt_i [*5] |-> channel_one_sink_o == '0)
        else $error("current under undervoltage");
    armed_zero_a: assert property ($rose(enabled_o) |->
        channel_one_sink_o == '0 && sink_oe_o && !pump_gain_1p5x_o)
        else $error("wake state wrong");
    pump_early_a: assert property ($rose(pump_gain_1p5x_o) |-> fail_cnt >= PUMP_CYC)
        else $error("pump switched too early");
    pump_due_a: assert property (fail_cnt == PUMP_CYC + 6 |-> pump_gain_1p5x_o)
        else $error("pump did not switch");
endmodule : pcd_link_assertions

// >>> dv/pulse_count_led_dimmer_tb.sv
// Purpose: drives host requests and checks the dimmer's levels
// Assumes: shortened shutdown, pump and setup counts
// Notes:   pulses are 60 low and 65 high cycles, a 1 MHz train
`timescale 1ns/1ps
module pulse_count_led_dimmer_tb
    import pcd_pkg::*;
;
    localparam int SH = 200;
    localparam int PU = 100;
    localparam logic [LEVEL_W:0] LUT [32] = '{9'h12c, 9'h122, 9'h118, 9'h10f, 9'h106,
        9'h0fc, 9'h0f2, 9'h0e8, 9'h0de, 9'h0d5, 9'h0cb, 9'h0c2, 9'h0b8, 9'h0ae, 9'h0a4,
        9'h09b, 9'h091, 9'h088, 9'h07e, 9'h074, 9'h06a, 9'h061, 9'h057, 9'h04e, 9'h044,
        9'h03a, 9'h030, 9'h026, 9'h01d, 9'h014, 9'h00a, 9'h000};
    logic             ref_clk;
    logic             resetn;
    logic             req;
    logic [STEP_W:0]  cnt;
    logic             shd;
    logic             uv;
    logic             rf;
    logic             rdy;
    logic             en;
    logic             oe;
    logic             gain;
    logic [LEVEL_W:0] ch1;
    logic [LEVEL_W:0] ch2;
    logic [LEVEL_W:0] prev;
    logic [LEVEL_W:0] exp_q [$];
    logic [31:0]      seed;
    int               n_fail;
    int               samples_checked;
    int               model;
    pcd_link_if       link ();
    pcd_host #(.SETUP_CYC(20), .SHDN_CYC(SH),
        .LOW_CYC(60), .HIGH_CYC(65)) u_pcd_host (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .link(link.host), .pulse_req_i(req),
        .pulse_count_i(cnt), .shutdown_req_i(shd), .ready_o(rdy));
    pcd_dimmer #(.SHDN_CYC(SH), .PUMP_CYC(PU)) u_pcd_dimmer (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .link(link.device), .undervolt_i(uv),
        .reg_fail_i(rf), .enabled_o(en), .channel_one_sink_o(ch1),
        .channel_two_sink_o(ch2), .sink_oe_o(oe), .pump_gain_1p5x_o(gain));
    pcd_link_assertions #(.SHDN_CYC(SH), .PUMP_CYC(PU)) u_pcd_link_assertions (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .enable_dim_input(link.enable_dim_input),
        .undervolt_i(uv), .reg_fail_i(rf), .enabled_o(en), .channel_one_sink_o(ch1),
        .channel_two_sink_o(ch2), .sink_oe_o(oe), .pump_gain_1p5x_o(gain));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xs
    task automatic chk(input logic [LEVEL_W:0] got, input logic [LEVEL_W:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Sampled on the falling edge, clear of the host's update
    task automatic wait_rdy();
        int i;
        i = 0;
        while (rdy !== 1'b1 && i < 8000) begin
            @(negedge ref_clk);
            i++;
        end
        if (i == 8000) n_fail++;
    endtask : wait_rdy
    // Every fall steps first, a shutdown request included
    task automatic send(input int n, input logic off);
        wait_rdy();
        for (int k = 0; k < (off ? 1 : n); k++) begin
            model = (model == 32) ? 1 : model + 1;
            exp_q.push_back(LUT[model-1]);
        end
        if (off && LUT[model-1] != '0) exp_q.push_back(9'h000);
        if (off) model = 0;
        @(posedge ref_clk);
        req <= !off;
        shd <= off;
        cnt <= n[STEP_W:0];
        @(posedge ref_clk);
        req <= 1'b0;
        shd <= 1'b0;
        @(negedge ref_clk);
    endtask : send
    task automatic final_report();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // Clock, monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (resetn && ch1 !== prev) begin
            chk(ch1, (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff);
            chk(ch2, ch1);
        end
        prev <= ch1;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {resetn, req, shd, uv, rf} = '0;
        cnt = '0;
        prev = '0;
        seed = 32'h675b;
        {n_fail, samples_checked, model} = '0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        wait_rdy();
        chk({8'h00, en}, 9'h001);
        chk({8'h00, oe}, 9'h001);
        chk(ch1, 9'h000);
        $display("test wake done");
        send(1, 1'b0);
        send(9, 1'b0);
        send(33, 1'b0);
        for (int t = 0; t < 4; t++) begin
            seed = xs(seed);
            send(int'(seed % 40) + 1, 1'b0);
        end
        $display("test steps done");
        if (model == 32) send(1, 1'b0);
        wait_rdy();
        @(posedge ref_clk);
        uv <= 1'b1;
        exp_q.push_back(9'h000);
        repeat (20) @(posedge ref_clk);
        uv <= 1'b0;
        exp_q.push_back(LUT[model-1]);
        repeat (20) @(posedge ref_clk);
        chk({8'h00, en}, 9'h001);
        $display("test undervoltage done");
        rf <= 1'b1;
        repeat (PU + 20) @(posedge ref_clk);
        chk({8'h00, gain}, 9'h001);
        rf <= 1'b0;
        $display("test pump done");
        send(0, 1'b1);
        repeat (SH + 8) @(negedge ref_clk);
        chk({7'h00, en, oe}, 9'h000);
        wait_rdy();
        chk({7'h00, en, gain}, 9'h002);
        send(2, 1'b0);
        wait_rdy();
        repeat (10) @(posedge ref_clk);
        chk(9'(exp_q.size()), 9'h000);
        $display("test shutdown done");
        final_report();
    end
endmodule : pulse_count_led_dimmer_tb
